// ===== verilog/iso_dv_framer_params.svh
// Purpose: register map, field positions, codes and counts of the iso/DV transmit framer
// Assumes: host register port with 9-bit byte addresses, 32-bit data
// Notes: every address, control bit, code and count the framer uses lives here as a macro
`ifndef ISO_DV_FRAMER_PARAMS_SVH
`define ISO_DV_FRAMER_PARAMS_SVH
`define ADDR_ISO_CTL 9'h0EC
`define ADDR_DV_CTL 9'h0F0
`define ADDR_STATUS 9'h130
`define ADDR_ISO_CONT 9'h134
`define ADDR_ISO_LAST 9'h138
`define ADDR_DV_A 9'h160
`define ADDR_DV_B 9'h164
`define ADDR_ISO_HDR 9'h1C0
`define ADDR_DV_HDR 9'h1C4
`define ADDR_CIP0 9'h1C8
`define ADDR_CIP1 9'h1CC
`define ADDR_XTO 9'h1D0
`define ISO_EN 0
`define ISO_BSEL 1
`define ISO_AUTO 2
`define ISO_FLUSH 3
`define DV_EN 0
`define DV_BSEL 1
`define DV_IL 2
`define DV_H0 3
`define HDR_MULTI 24
`define CTL_RST 32'h0000_0000
`define FMT_LAST 3'h2
`define FMT_FIRST 3'h5
`define FIFO_DEPTH 128
`define SP_QUADS 7'h78
`define DV_NEED_RAW 8'h7B
`define H0_QUADS 16'h0014
`define H0_EVERY 5'h1A
`define DIF_SEQ_LAST 4'h9
`define DBC_WRAP 8'hFF
`define H0_ID 8'h1F
`endif

// ===== verilog/iso_dv_framer_pkg.sv
// Purpose: shared types of the iso/DV transmit framer
// Assumes: nothing beyond the params header
// Notes: Gray codes follow idle, arbitrate, header, CIP, H0, data
package iso_dv_framer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB = 3'h1,
    ST_HDR = 3'h3,
    ST_CIP0 = 3'h2,
    ST_CIP1 = 3'h6,
    ST_H0 = 3'h7,
    ST_DATA = 3'h5
  } fsm_t;
endpackage : iso_dv_framer_pkg

// ===== verilog/two_entry_buffer.sv
// Purpose: two-entry valid/ready buffer between framer engine and link
// Assumes: single clock, synchronous reset
// Notes: head and tail are flops; output data comes straight from head
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(parameter int W = 33) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic hv;
    logic tv;
    logic [W-1:0] hd;
    logic [W-1:0] td;
  } buf_t;
  buf_t s, n;
  // ready only while tail is free, so a stalled link never loses a word
  assign in_ready_o = ~s.tv;
  assign out_valid_o = s.hv;
  assign out_data_o = s.hd;
  // ****************************************
  // shift head/tail
  // ****************************************
  always_comb begin
    n = s;
    if (s.hv && out_ready_i) begin
      n.hv = s.tv;
      n.hd = s.tv ? s.td : '0; // empty head shows zero, so no stale last flag
      n.tv = 1'b0;
    end
    if (in_valid_i && !s.tv) begin
      if (!n.hv) begin
        n.hv = 1'b1;
        n.hd = in_data_i;
      end else begin
        n.tv = 1'b1;
        n.td = in_data_i;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

// ===== verilog/iso_dv_transmit_framer.sv
// Purpose: iso and DV transmit framer, host register port, bulky byte port, link stream
// Assumes: host port and cycle/timer inputs share clk_i; bulky pins and frame pulse do not
// Notes: one FIFO serves iso or DV traffic, whichever mode is enabled
`include "iso_dv_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iso_dv_transmit_framer #(parameter int DEPTH = `FIFO_DEPTH) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [8:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  input wire logic [7:0] bulky_byte_i,
  input wire logic [2:0] bulky_fmt_i,
  input wire logic bulky_strobe_i,
  input wire logic frame_pulse_i,
  input wire logic iso_cycle_i,
  input wire logic [31:0] cycle_timer_i,
  output logic tx_arb_o,
  output logic [31:0] tx_data_o,
  output logic tx_last_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);
  import iso_dv_framer_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [31:0] iso_ctl;
    logic [31:0] dv_ctl;
    logic [31:0] iso_hdr;
    logic [31:0] dv_hdr;
    logic [31:0] cip0;
    logic [31:0] cip1;
    logic [31:0] transmit_offset_value;
    logic [31:0] asm_q;
    logic [1:0] bpos;
    logic [15:0] pbytes;
    logic [15:0] plen;
    logic hdr_seen;
    logic [7:0] pkts;
    logic [6:0] sp_q;
    logic [4:0] sp_n;
    logic [3:0] dif_seq;
    fsm_t st;
    logic [15:0] left;
    logic multi;
    logic full;
    logic cyc;
    logic [2:0] sb;
    logic [2:0] sfr;
    logic [1:0][7:0] sd;
    logic [1:0][2:0] sfm;
    logic [31:0] rdata;
    logic arb;
  } st_t;
  st_t s, n;

  logic push, hlast, blast, flush, pop, cinc, pk_inc, pk_dec, from_fifo, acc;
  logic own_iso_host, own_iso_bulky, own_dv_host, own_dv_bulky, dv_en, il;
  logic eng_valid, eng_last, buf_ready;
  logic [31:0] pword, eng_word, cur;
  logic [1:0] pos;
  logic [15:0] nbytes, newb, plen_eff, qw;
  logic [32:0] out_q;

  // whole quadlets needed for a byte length
  function automatic logic [15:0] qwords(input logic [15:0] len);
    logic [17:0] t;
    t = {2'b00, len} + 18'd3;
    return t[17:2];
  endfunction : qwords

  assign dv_en = s.dv_ctl[`DV_EN];
  assign il = s.dv_ctl[`DV_IL];
  assign own_iso_host = s.iso_ctl[`ISO_EN] & ~s.iso_ctl[`ISO_BSEL] & ~dv_en;
  assign own_iso_bulky = s.iso_ctl[`ISO_EN] & s.iso_ctl[`ISO_BSEL] & ~dv_en;
  assign own_dv_bulky = dv_en & s.dv_ctl[`DV_BSEL];
  assign own_dv_host = dv_en & ~s.dv_ctl[`DV_BSEL];
  assign host_rdata_o = s.rdata;
  assign tx_arb_o = s.arb;
  assign tx_data_o = out_q[31:0];
  assign tx_last_o = out_q[32];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.arb = 1'b0;
    push = 1'b0;
    hlast = 1'b0;
    blast = 1'b0;
    flush = 1'b0;
    pop = 1'b0;
    cinc = 1'b0;
    pk_inc = 1'b0;
    pk_dec = 1'b0;
    from_fifo = 1'b0;
    pword = 32'h0000_0000;
    nbytes = 16'h0004;
    newb = 16'h0000;
    plen_eff = 16'h0000;
    cur = s.asm_q;
    pos = s.bpos;
    eng_valid = 1'b0;
    eng_word = 32'h0000_0000;
    eng_last = 1'b0;
    qw = 16'h0000;
    acc = 1'b0;
    // pins pass two flops before use; third flop is only for edge detect
    n.sb = {s.sb[1:0], bulky_strobe_i};
    n.sfr = {s.sfr[1:0], frame_pulse_i};
    n.sd[0] = bulky_byte_i;
    n.sd[1] = s.sd[0];
    n.sfm[0] = bulky_fmt_i;
    n.sfm[1] = s.sfm[0];
    n.cyc = s.cyc | iso_cycle_i;
    // host register writes, address decode
    if (host_wr_i) begin
      if (host_addr_i == `ADDR_ISO_CTL) begin
        n.iso_ctl = host_wdata_i;
        n.iso_ctl[`ISO_FLUSH] = 1'b0;
        flush = host_wdata_i[`ISO_FLUSH];
      end else if (host_addr_i == `ADDR_DV_CTL) begin
        n.dv_ctl = host_wdata_i;
      end else if (host_addr_i == `ADDR_ISO_HDR) begin
        n.iso_hdr = host_wdata_i;
      end else if (host_addr_i == `ADDR_DV_HDR) begin
        n.dv_hdr = host_wdata_i;
      end else if (host_addr_i == `ADDR_CIP0) begin
        n.cip0 = host_wdata_i;
      end else if (host_addr_i == `ADDR_CIP1) begin
        n.cip1 = host_wdata_i;
      end else if (host_addr_i == `ADDR_XTO) begin
        n.transmit_offset_value = host_wdata_i;
      end else if ((host_addr_i == `ADDR_ISO_CONT || host_addr_i == `ADDR_ISO_LAST)
                   && own_iso_host) begin
        push = 1'b1;
        pword = host_wdata_i;
        hlast = (host_addr_i == `ADDR_ISO_LAST);
      end else if ((host_addr_i == `ADDR_DV_A || host_addr_i == `ADDR_DV_B) && own_dv_host) begin
        push = 1'b1;
        pword = host_wdata_i;
      end
    end
    // register reads, unmapped reads as zero
    if (host_rd_i) begin
      if (host_addr_i == `ADDR_ISO_CTL) begin
        n.rdata = s.iso_ctl;
      end else if (host_addr_i == `ADDR_DV_CTL) begin
        n.rdata = s.dv_ctl;
      end else if (host_addr_i == `ADDR_STATUS) begin
        n.rdata = {s.pkts, 1'b0, s.sp_q, 16'(s.cnt)};
      end else if (host_addr_i == `ADDR_ISO_HDR) begin
        n.rdata = s.iso_hdr;
      end else if (host_addr_i == `ADDR_DV_HDR) begin
        n.rdata = s.dv_hdr;
      end else if (host_addr_i == `ADDR_CIP0) begin
        n.rdata = s.cip0;
      end else if (host_addr_i == `ADDR_CIP1) begin
        n.rdata = s.cip1;
      end else if (host_addr_i == `ADDR_XTO) begin
        n.rdata = s.transmit_offset_value;
      end else begin
        n.rdata = 32'h0000_0000;
      end
    end
    // bulky byte assembly, first byte lands in the top lane
    if (s.sb[1] && !s.sb[2] && (own_iso_bulky || own_dv_bulky)) begin
      if (own_dv_bulky && s.sfm[1] == `FMT_FIRST) begin
        cur = 32'h0000_0000;
        pos = 2'd0;
        n.sp_q = 7'd0;
      end
      cur[8*(3-pos) +: 8] = s.sd[1];
      blast = own_iso_bulky && (s.sfm[1] == `FMT_LAST);
      if (pos == 2'd3 || blast) begin
        push = 1'b1;
        pword = cur;
        nbytes = 16'(pos) + 16'd1;
        n.asm_q = 32'h0000_0000;
        n.bpos = 2'd0;
      end else begin
        n.asm_q = cur;
        n.bpos = pos + 2'd1;
      end
    end
    // FIFO push and iso packet completion; a full FIFO drops the word
    if (push && s.cnt != (AW+1)'(DEPTH)) begin
      cinc = 1'b1;
      n.mem[s.wp] = pword;
      n.wp = s.wp + 1'b1;
      if (dv_en) begin
        n.sp_q = (n.sp_q == `SP_QUADS - 7'd1) ? 7'd0 : n.sp_q + 7'd1;
      end else begin
        plen_eff = s.iso_ctl[`ISO_AUTO] ? s.iso_hdr[31:16] : s.plen;
        newb = s.pbytes + nbytes;
        if (!s.iso_ctl[`ISO_AUTO] && !s.hdr_seen) begin
          n.hdr_seen = 1'b1;
          plen_eff = pword[31:16];
          n.plen = pword[31:16];
          newb = 16'h0000;
        end
        if (hlast || blast || newb >= plen_eff) begin
          pk_inc = 1'b1;
          n.pbytes = 16'h0000;
          n.hdr_seen = 1'b0;
        end else begin
          n.pbytes = newb;
        end
      end
    end
    // frame pulse stamps the CIP timestamp field when DV_IL is set
    if (s.sfr[1] && !s.sfr[2] && il) begin
      n.cip1[15:0] = cycle_timer_i[15:0] + s.transmit_offset_value[15:0];
    end
    // ****************************************
    // transmit engine
    // ****************************************
    case (s.st)
      ST_IDLE: begin
        if (dv_en) begin
          if (iso_cycle_i) begin
            n.full = s.cnt >= (il ? (AW+1)'(`SP_QUADS) : (AW+1)'(`DV_NEED_RAW));
            n.st = ST_ARB;
          end
        end else if (s.iso_ctl[`ISO_EN] && n.cyc && s.pkts != 8'd0) begin
          n.st = ST_ARB;
        end
      end
      ST_ARB: begin
        n.arb = 1'b1;
        n.cyc = iso_cycle_i;
        n.st = ST_HDR;
      end
      ST_HDR: begin
        from_fifo = dv_en ? (!il && s.full) : !s.iso_ctl[`ISO_AUTO];
        eng_word = from_fifo ? s.mem[s.rp] : (dv_en ? s.dv_hdr : s.iso_hdr);
        qw = qwords(eng_word[31:16]);
        eng_last = !dv_en && qw == 16'h0000;
        eng_valid = 1'b1;
      end
      ST_CIP0: begin
        from_fifo = !il && s.full;
        eng_word = from_fifo ? s.mem[s.rp] : s.cip0;
        eng_valid = 1'b1;
      end
      ST_CIP1: begin
        from_fifo = !il && s.full;
        eng_word = from_fifo ? s.mem[s.rp] : s.cip1;
        eng_last = !s.full;
        eng_valid = 1'b1;
      end
      ST_H0: begin
        eng_word = (s.left == `H0_QUADS) ? {`H0_ID, s.dif_seq, 20'h0_0000} : 32'h0000_0000;
        eng_valid = 1'b1;
      end
      ST_DATA: begin
        from_fifo = 1'b1;
        eng_word = s.mem[s.rp];
        eng_last = s.left == 16'h0001;
        eng_valid = 1'b1;
      end
      default: n.st = ST_IDLE;
    endcase
    // stall rather than read an empty FIFO
    if (from_fifo && s.cnt == '0) begin
      eng_valid = 1'b0;
    end
    acc = eng_valid & buf_ready;
    if (acc) begin
      pop = from_fifo;
      case (s.st)
        ST_HDR: begin
          if (dv_en) begin
            n.st = ST_CIP0;
          end else begin
            n.multi = eng_word[`HDR_MULTI];
            n.left = qw;
            n.st = ST_DATA;
            if (qw == 16'h0000) begin
              pk_dec = 1'b1;
              n.st = (eng_word[`HDR_MULTI] && s.pkts > 8'd1) ? ST_ARB : ST_IDLE;
            end
          end
        end
        ST_CIP0: n.st = ST_CIP1;
        ST_CIP1: begin
          if (!s.full) begin
            n.st = ST_IDLE;
          end else if (s.dv_ctl[`DV_H0] && s.sp_n == 5'd0) begin
            n.left = `H0_QUADS;
            n.st = ST_H0;
          end else begin
            n.left = 16'(`SP_QUADS);
            n.st = ST_DATA;
          end
        end
        ST_H0: begin
          n.left = s.left - 16'h0001;
          if (s.left == 16'h0001) begin
            n.left = 16'(`SP_QUADS);
            n.st = ST_DATA;
            n.dif_seq = (s.dif_seq == `DIF_SEQ_LAST) ? 4'h0 : s.dif_seq + 4'h1;
          end
        end
        ST_DATA: begin
          n.left = s.left - 16'h0001;
          if (s.left == 16'h0001) begin
            if (dv_en) begin
              n.cip0[7:0] = (s.cip0[7:0] == `DBC_WRAP - 8'd1) ? 8'd0 : s.cip0[7:0] + 8'd1;
              n.sp_n = (s.sp_n == `H0_EVERY - 5'd1) ? 5'd0 : s.sp_n + 5'd1;
              n.st = ST_IDLE;
            end else begin
              pk_dec = 1'b1;
              n.st = (s.multi && s.pkts > 8'd1) ? ST_ARB : ST_IDLE;
            end
          end
        end
        default: n.st = s.st;
      endcase
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    if (cinc && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (!cinc && pop) begin
      n.cnt = s.cnt - 1'b1;
    end
    if (pk_inc && !pk_dec) begin
      n.pkts = s.pkts + 8'd1;
    end else if (!pk_inc && pk_dec) begin
      n.pkts = s.pkts - 8'd1;
    end
    // flush wins over everything in flight
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
      n.pkts = 8'd0;
      n.asm_q = 32'h0000_0000;
      n.bpos = 2'd0;
      n.pbytes = 16'h0000;
      n.hdr_seen = 1'b0;
      n.sp_q = 7'd0;
      n.st = ST_IDLE;
    end
  end

  // ****************************************
  // output buffer and registers
  // ****************************************
  two_entry_buffer #(.W(33)) u_out_buf (
    .clk_i(clk_i),
    .srst_i(srst_i | flush),
    .in_valid_i(eng_valid & ~flush),
    .in_data_i({eng_last, eng_word}),
    .in_ready_o(buf_ready),
    .out_valid_o(tx_valid_o),
    .out_data_o(out_q),
    .out_ready_i(tx_ready_i)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.iso_ctl <= `CTL_RST;
      s.dv_ctl <= `CTL_RST;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end
endmodule : iso_dv_transmit_framer
`default_nettype wire

// ===== verif/iso_dv_framer_monitor.sv
// Purpose: port checks of the iso/DV transmit framer
// Assumes: one clock, sync reset
// Notes: DV enable and packet word count rebuilt from ports
`include "iso_dv_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iso_dv_framer_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [8:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic iso_cycle_i,
  input wire logic tx_arb_o,
  input wire logic [31:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i
);
  // ****************
  // helpers
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic flush_w;
  logic flush_d_r;
  logic dv_en_r;
  logic [7:0] wcnt_r;
  assign flush_w = host_wr_i && host_addr_i == `ADDR_ISO_CTL && host_wdata_i[`ISO_FLUSH];
  // flush resets the engine, so the word count restarts with it
  always_ff @(posedge clk_i) begin
    if (srst_i || flush_w) begin
      wcnt_r <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      wcnt_r <= tx_last_o ? 8'h00 : wcnt_r + 8'h01;
    end
    flush_d_r <= !srst_i && flush_w;
    if (srst_i) begin
      dv_en_r <= 1'b0;
    end else if (host_wr_i && host_addr_i == `ADDR_DV_CTL) begin
      dv_en_r <= host_wdata_i[`DV_EN];
    end
  end
  // ****************
  // checks
  // ****************
  sequence s_arb;
    tx_arb_o ##1 !tx_arb_o;
  endsequence
  sequence s_stall;
    tx_valid_o && !tx_ready_i && !flush_w && !flush_d_r;
  endsequence
  a_valid_hold: assert property (s_stall |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("stream word changed while stalled");
  a_last_qualified: assert property (tx_last_o |-> tx_valid_o)
    else $error("last without valid");
  a_dv_length: assert property (tx_valid_o && tx_ready_i && tx_last_o && dv_en_r |->
    wcnt_r == 8'd2 || wcnt_r == 8'd122 || wcnt_r == 8'd142)
    else $error("dv packet of wrong length");
  a_arb_single: assert property (tx_arb_o |-> s_arb)
    else $error("arbitration request longer than one cycle");
  a_arb_then_data: assert property (s_arb |-> ##[0:3] tx_valid_o)
    else $error("no word after arbitration");
  a_flush_clears: assert property (flush_w |-> ##[1:2] !tx_valid_o)
    else $error("stream still valid after flush");
  a_flush_self_clear: assert property (host_rd_i && host_addr_i == `ADDR_ISO_CTL |=>
    !host_rdata_o[`ISO_FLUSH])
    else $error("flush bit reads back set");
  a_dv_cycle_arb: assert property (iso_cycle_i && dv_en_r |-> ##[1:4] tx_arb_o)
    else $error("no dv packet in cycle");
endmodule : iso_dv_framer_monitor
`default_nettype wire

// ===== verif/link_sink.sv
// Purpose: link side model taking the framer's quadlet stream
// Assumes: testbench reads the captured queues
// Notes: stall mode accepts on every other cycle
`timescale 1ns/1ps
`default_nettype none
module link_sink (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tx_arb_i,
  input wire logic [31:0] tx_data_i,
  input wire logic tx_last_i,
  input wire logic tx_valid_i,
  input wire logic stall_i,
  output logic tx_ready_o = 1'b0
);
  // ****************
  // capture
  // ****************
  logic [31:0] words[$];
  logic lasts[$];
  int arbs = 0;
  // words recorded in bus order, arbitration requests counted
  always @(posedge clk_i) begin
    if (srst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_valid_i && tx_ready_o) begin
        words.push_back(tx_data_i);
        lasts.push_back(tx_last_i);
      end
      if (tx_arb_i) arbs <= arbs + 1;
      tx_ready_o <= stall_i ? !tx_ready_o : 1'b1;
    end
  end
endmodule : link_sink
`default_nettype wire

// ===== verif/tb_iso_dv_transmit_framer.sv
// Purpose: self-checking bench of the iso/DV transmit framer
// Assumes: host port, bulky pins and cycle pulse driven here
// Notes: link stream captured by link_sink
`include "iso_dv_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_iso_dv_transmit_framer;
  // ****************
  // stimulus and plumbing
  // ****************
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic host_wr_i = 1'b0;
  logic host_rd_i = 1'b0;
  logic [8:0] host_addr_i = 9'h000;
  logic [31:0] host_wdata_i = 32'h0000_0000;
  logic [31:0] host_rdata_o;
  logic [7:0] bulky_byte_i = 8'h00;
  logic [2:0] bulky_fmt_i = 3'h0;
  logic bulky_strobe_i = 1'b0;
  logic iso_cycle_i = 1'b0;
  logic tx_arb_o, tx_last_o, tx_valid_o, tx_ready_i;
  logic stall = 1'b0;
  logic frame_pulse = 1'b0;
  logic [31:0] ctimer = 32'h0000_1234;
  logic [31:0] tx_data_o;
  int num_errors = 0;
  int tests_run = 0;
  always #25 clk_i = ~clk_i;
  iso_dv_transmit_framer u_dut (.clk_i(clk_i), .srst_i(srst_i), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o), .bulky_byte_i(bulky_byte_i), .bulky_fmt_i(bulky_fmt_i),
    .bulky_strobe_i(bulky_strobe_i), .frame_pulse_i(frame_pulse), .iso_cycle_i(iso_cycle_i),
    .cycle_timer_i(ctimer), .tx_arb_o(tx_arb_o), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
  link_sink u_link (.clk_i(clk_i), .srst_i(srst_i), .tx_arb_i(tx_arb_o), .tx_data_i(tx_data_o),
    .tx_last_i(tx_last_o), .tx_valid_i(tx_valid_o), .stall_i(stall), .tx_ready_o(tx_ready_i));
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= d;
    @(posedge clk_i);
    host_wr_i <= 1'b0;
  endtask : wr
  // read data looked at one edge late; it stands until the next read
  task automatic rd_chk(input string what, input logic [8:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    @(posedge clk_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge clk_i);
    host_rd_i <= 1'b0;
    @(posedge clk_i);
    #1 chk32(what, exp, host_rdata_o & m);
  endtask : rd_chk
  task automatic cnt_is(input logic [31:0] exp);
    rd_chk("fifo count", `ADDR_STATUS, 32'h0000_FFFF, exp);
  endtask : cnt_is
  // strobe spacing kept wide of the sync chain, data held around the edge
  task automatic bulky(input logic [7:0] b, input logic [2:0] f);
    @(posedge clk_i);
    bulky_byte_i <= b;
    bulky_fmt_i <= f;
    repeat (3) @(posedge clk_i);
    bulky_strobe_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    bulky_strobe_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : bulky
  task automatic cyc();
    u_link.words.delete();
    u_link.lasts.delete();
    @(posedge clk_i);
    iso_cycle_i <= 1'b1;
    @(posedge clk_i);
    iso_cycle_i <= 1'b0;
  endtask : cyc
  task automatic wait_pkt(input int n);
    int k;
    for (k = 0; k < 3000 && u_link.words.size() < n; k++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk32("word count", n, u_link.words.size());
    for (k = 0; k < u_link.lasts.size(); k++) chk32("last flag", k == n - 1, u_link.lasts[k]);
  endtask : wait_pkt
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rd_chk("iso ctl reset", `ADDR_ISO_CTL, 32'hFFFF_FFFF, `CTL_RST);
    rd_chk("dv ctl reset", `ADDR_DV_CTL, 32'hFFFF_FFFF, `CTL_RST);
    rd_chk("unmapped", 9'h100, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : t_regs
  task automatic t_flush();
    wr(`ADDR_ISO_CTL, 32'h0000_0001);
    wr(`ADDR_ISO_CONT, 32'h0008_00A0);
    wr(`ADDR_ISO_CONT, 32'hCAFE_0001);
    cnt_is(32'h2);
    wr(`ADDR_ISO_CTL, 32'h0000_0009);
    cnt_is(32'h0);
    rd_chk("flush self clear", `ADDR_ISO_CTL, 32'hFFFF_FFFF, 32'h0000_0001);
  endtask : t_flush
  task automatic t_iso_host();
    wr(`ADDR_ISO_CONT, 32'h0008_00A0);
    wr(`ADDR_ISO_CONT, 32'h1111_2222);
    cyc();
    repeat (10) @(posedge clk_i);
    chk32("early words", 0, u_link.words.size());
    wr(`ADDR_ISO_LAST, 32'h3333_4444);
    cyc();
    wait_pkt(3);
    chk32("iso header", 32'h0008_00A0, u_link.words[0]);
    chk32("iso data", 32'h3333_4444, u_link.words[2]);
  endtask : t_iso_host
  task automatic t_bulky();
    logic [55:0] hb;
    hb = 56'h0005_00A0_1122_33;
    wr(`ADDR_ISO_CTL, 32'h0000_0003);
    bulky(8'hAA, 3'h0);
    bulky(8'hBB, 3'h0);
    wr(`ADDR_ISO_CTL, 32'h0000_000B);
    for (int i = 0; i < 7; i++) bulky(hb[55-8*i -: 8], 3'h0);
    cnt_is(32'h1);
    bulky(8'h44, 3'h0);
    cnt_is(32'h2);
    // cycle flag is already pending, so the packet leaves right after its last byte
    cyc();
    bulky(8'h55, `FMT_LAST);
    wait_pkt(3);
    chk32("bulky quadlet", 32'h1122_3344, u_link.words[1]);
    chk32("padded quadlet", 32'h5500_0000, u_link.words[2]);
    wr(`ADDR_ISO_CTL, 32'h0000_0008);
  endtask : t_bulky
  task automatic t_dv();
    wr(`ADDR_DV_HDR, 32'h01E4_00A0);
    wr(`ADDR_XTO, 32'h0000_0100);
    wr(`ADDR_DV_CTL, 32'h0000_0005);
    frame_pulse <= 1'b1;
    repeat (4) @(posedge clk_i);
    frame_pulse <= 1'b0;
    cyc();
    wait_pkt(3);
    chk32("dv header", 32'h01E4_00A0, u_link.words[0]);
    chk32("timestamp", 32'h0000_1334, u_link.words[2]);
    rd_chk("dbc start", `ADDR_CIP0, 32'h0000_00FF, 32'h0);
    for (int i = 0; i < 4; i++) bulky(8'h77, 3'h0);
    cnt_is(32'h0);
    for (int i = 0; i < 120; i++) wr(i[0] ? `ADDR_DV_B : `ADDR_DV_A, i);
    stall <= 1'b1;
    cyc();
    wait_pkt(123);
    for (int i = 0; i < 120; i++) chk32("dv data", i, u_link.words[3+i]);
    stall <= 1'b0;
    rd_chk("dbc after packet", `ADDR_CIP0, 32'h0000_00FF, 32'h1);
    // junk bytes, then a first-byte code restarts the quadlet and source counter
    wr(`ADDR_DV_CTL, 32'h0000_0003);
    bulky(8'h99, 3'h0);
    bulky(8'h98, 3'h0);
    bulky(8'hF0, `FMT_FIRST);
    for (int i = 1; i < 4; i++) bulky(8'hF0 + i[7:0], 3'h0);
    rd_chk("dv first restart", `ADDR_STATUS, 32'h007F_FFFF, 32'h0001_0001);
    wr(`ADDR_ISO_CTL, 32'h0000_0008);
    wr(`ADDR_DV_CTL, 32'h0000_0000);
  endtask : t_dv
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_flush();
    t_iso_host();
    t_bulky();
    t_dv();
    wrap_up();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule : tb_iso_dv_transmit_framer
bind iso_dv_transmit_framer iso_dv_framer_monitor u_mon (.clk_i(clk_i), .srst_i(srst_i),
  .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .iso_cycle_i(iso_cycle_i),
  .tx_arb_o(tx_arb_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
`default_nettype wire
